// ===== rtl/cific_control.sv
// instruction fetch, stack lookup, issue and jump sequencing
`timescale 1ns/1ps
module cific_control
(
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     nonseq_variant,
  input  wire logic                     overlap_units,
  input  wire logic [1:0]               maint_rank_off,
  input  wire logic                     issue_permit,
  input  wire logic                     mem_valid,
  input  wire logic [59:0]              mem_data,
  input  wire logic                     exit_to_monitor,
  input  wire cific_pkg::cific_regs_type regs,
  input  wire logic                     copy_done,
  input  wire logic                     xchg_go,
  input  wire logic [17:0]              xchg_pkg_addr,
  input  wire logic [17:0]              xchg_new_p,
  output logic                          mem_req,
  output logic [17:0]                   mem_addr,
  output logic                          issue_valid,
  output logic [59:0]                   issue_word,
  output logic [2:0]                    issue_len,
  output cific_pkg::cific_unit_type     issue_unit,
  output logic [2:0]                    sel_i,
  output logic [2:0]                    sel_j,
  output cific_pkg::cific_copy_type     copy,
  output cific_pkg::cific_xchg_type     xchg,
  output logic                          store_valid,
  output logic [17:0]                   store_addr,
  output logic                          stopped,
  output logic [17:0]                   program_address
);
  typedef enum logic [2:0]
  {st_look, st_load, st_issue, st_copy, st_xreq, st_xchg, st_xend, st_stop}
    cific_fsm_type;

  typedef struct packed {
    cific_fsm_type             fsm;
    logic [17:0]               p;
    logic [17:0]               fetch_p;
    logic                      fetch_busy;
    logic                      drop;
    logic [17:0]               pend_addr;
    logic                      push;
    logic [59:0]               push_word;
    logic [17:0]               push_addr;
    logic                      void_stk;
    logic                      branch_chk;
    logic [59:0]               issue_word_register;
    logic [1:0]                parcel;
    logic                      mem_req;
    logic [17:0]               mem_addr;
    logic                      issue_valid;
    logic [59:0]               issue_word;
    logic [2:0]                issue_len;
    cific_pkg::cific_unit_type issue_unit;
    logic [2:0]                sel_i;
    logic [2:0]                sel_j;
    logic                      mul_last;
    logic [5:0]                mul_cnt;
    logic [5:0]                div_cnt;
    logic [5:0]                gen_cnt;
    cific_pkg::cific_copy_type copy;
    cific_pkg::cific_xchg_type xchg;
    logic [17:0]               xchg_base;
    logic [3:0]                xcnt;
    logic                      store_valid;
    logic [17:0]               store_addr;
    logic                      stopped;
  } cific_ctl_type;

  cific_ctl_type state;
  cific_ctl_type next_state;
  logic          s_hit;
  logic [59:0]   s_word;
  logic [11:0]   rank_off;

  function automatic logic [59:0] at_parcel(input logic [59:0] w,
                                            input logic [1:0] pc);
    logic [59:0] r;
    r = w;
    case (pc)
      2'h1: r = {w[44:0], 15'h0000};
      2'h2: r = {w[29:0], 30'h00000000};
      2'h3: r = {w[14:0], 45'h000000000000};
      default: r = w;
    endcase
    return r;
  endfunction

  always_comb
  begin
    rank_off = 12'h000;
    if (!nonseq_variant && maint_rank_off == cific_pkg::MAINT_TEN)
      rank_off = cific_pkg::RANK_OFF_TEN;
    else if (!nonseq_variant && maint_rank_off == cific_pkg::MAINT_FOUR)
      rank_off = cific_pkg::RANK_OFF_FOUR;
  end

  cific_stack u_stack
  (
    .clk         (clk),
    .srst        (srst),
    .void_stacks (state.void_stk),
    .push        (state.push),
    .push_word   (state.push_word),
    .push_addr   (state.push_addr),
    .rank_off    (rank_off),
    .look_addr   (state.p),
    .hit         (s_hit),
    .hit_word    (s_word)
  );

  always_comb
  begin
    logic [59:0] pw;
    logic [5:0]  fm;
    logic [2:0]  fi;
    logic [17:0] k;
    logic [2:0]  len;
    logic [2:0]  room;
    logic        blocked;
    logic        taken;
    logic        do_void;
    logic [10:0] ex;
    logic [17:0] tgt;
    cific_pkg::cific_unit_type unit;
    next_state = state;
    pw = at_parcel(state.issue_word_register, state.parcel);
    fm = pw[59:54];
    fi = pw[53:51];
    k = pw[47:30];
    len = 3'h1;
    room = 3'h4 - {1'b0, state.parcel};
    blocked = 1'b0;
    taken = 1'b0;
    do_void = 1'b0;
    ex = regs.operand_j[59] ? ~regs.operand_j[58:48] : regs.operand_j[58:48];
    tgt = k;
    unit = cific_pkg::unit_gen;
    next_state.push = 1'b0;
    next_state.void_stk = 1'b0;
    next_state.mem_req = 1'b0;
    next_state.issue_valid = 1'b0;
    next_state.mul_last = 1'b0;
    next_state.copy.start = 1'b0;
    next_state.xchg.ref_valid = 1'b0;
    next_state.store_valid = 1'b0;
    // units take a fixed time once issued, but a cycle with xchg_go in st_look, st_load, st_issue, st_xreq or st_stop holds all three counts
    if (state.mul_cnt != 6'h00)
      next_state.mul_cnt = state.mul_cnt - 6'h01;
    if (state.div_cnt != 6'h00)
      next_state.div_cnt = state.div_cnt - 6'h01;
    if (state.gen_cnt != 6'h00)
      next_state.gen_cnt = state.gen_cnt - 6'h01;

    if (mem_valid)
    begin
      next_state.fetch_busy = 1'b0;
      next_state.drop = 1'b0;
      if (!state.drop)
      begin
        next_state.push = 1'b1;
        next_state.push_word = mem_data;
        next_state.push_addr = state.pend_addr;
      end
    end
    // one read in flight; the stack only refills near the program address
    if (!state.fetch_busy && state.fsm != st_stop &&
        (state.fetch_p - state.p) <= cific_pkg::AHEAD)
    begin
      next_state.mem_req = 1'b1;
      next_state.mem_addr = state.fetch_p + regs.main_base;
      next_state.pend_addr = state.fetch_p;
      next_state.fetch_busy = 1'b1;
      next_state.fetch_p = state.fetch_p + 18'h00001;
    end

    if ((fm < 6'h08) || (fm[2:0] < 3'h3 && fm[5:4] != 2'h0 && fm[3]) ||
        (fm[2:0] < 3'h3 && fm[5:3] == 3'h6))
      len = 3'h2;
    if (fm == cific_pkg::FM_SEQ && fi[2])
      len = nonseq_variant ? 3'h2 : 3'h4;
    if (fm >= cific_pkg::FM_MUL_LO && fm <= cific_pkg::FM_MUL_HI)
      unit = cific_pkg::unit_mul;
    else if (fm >= cific_pkg::FM_DIV_LO && fm <= cific_pkg::FM_DIV_HI)
      unit = cific_pkg::unit_div;
    if (!overlap_units)
      blocked = (unit == cific_pkg::unit_mul && state.mul_cnt != 6'h00) ||
                (unit == cific_pkg::unit_div && state.div_cnt != 6'h00) ||
                (unit == cific_pkg::unit_gen && state.gen_cnt != 6'h00);
    else
      blocked = (unit == cific_pkg::unit_mul && state.mul_last) ||
                (unit == cific_pkg::unit_div &&
                 state.div_cnt > cific_pkg::DIV_OVERLAP);
    case (fm[2:0])
      3'h3:
        case (fi)
          3'h0: taken = regs.operand_j == '0 || &regs.operand_j;
          3'h1: taken = !(regs.operand_j == '0 || &regs.operand_j);
          3'h2: taken = !regs.operand_j[59];
          3'h3: taken = regs.operand_j[59];
          3'h4: taken = ex != cific_pkg::EXP_INF;
          3'h5: taken = ex == cific_pkg::EXP_INF;
          3'h6: taken = ex != cific_pkg::EXP_IND;
          default: taken = ex == cific_pkg::EXP_IND;
        endcase
      3'h4: taken = regs.index_i == regs.index_j;
      3'h5: taken = regs.index_i != regs.index_j;
      3'h6: taken = $signed(regs.index_i) >= $signed(regs.index_j);
      default: taken = $signed(regs.index_i) < $signed(regs.index_j);
    endcase

    case (state.fsm)
      st_look:
        next_state.fsm = st_load;
      st_load:
      begin
        next_state.fsm = st_look;
        next_state.branch_chk = 1'b0;
        if (s_hit)
        begin
          next_state.issue_word_register = s_word;
          next_state.parcel = 2'h0;
          next_state.fsm = st_issue;
        end
        else if (state.branch_chk && !nonseq_variant)
          do_void = 1'b1;
        else if (state.branch_chk || (!state.fetch_busy &&
                 (state.fetch_p - state.p) > cific_pkg::AHEAD))
          next_state.fetch_p = state.p;
      end
      st_issue:
        if (len > room)
        begin
          next_state.p = state.p + 18'h00001;
          next_state.fsm = st_look;
        end
        else if (issue_permit && !blocked)
        begin
          next_state.issue_valid = 1'b1;
          next_state.issue_word = pw;
          next_state.issue_len = len;
          next_state.issue_unit = unit;
          case (unit)
            cific_pkg::unit_mul:
            begin
              next_state.mul_cnt = cific_pkg::MUL_TIME;
              next_state.mul_last = 1'b1;
            end
            cific_pkg::unit_div:
              next_state.div_cnt = cific_pkg::DIV_TIME;
            default:
              next_state.gen_cnt = cific_pkg::GEN_TIME;
          endcase
          next_state.parcel = state.parcel + len[1:0];
          if (len == room)
          begin
            next_state.p = state.p + 18'h00001;
            next_state.fsm = st_look;
          end
          case (fm)
            cific_pkg::FM_EXIT:
            begin
              next_state.fsm = st_xreq;
              next_state.xchg.req_addr = {1'b0,
                                          regs.error_exit_pointer[16:0]};
              if (!nonseq_variant && exit_to_monitor)
                next_state.xchg.req_addr = regs.monitor_address;
              else if (!nonseq_variant)
              begin
                next_state.fsm = st_stop;
                next_state.stopped = 1'b1;
              end
            end
            cific_pkg::FM_SEQ:
              case (fi)
                cific_pkg::I_RJ:
                begin
                  next_state.store_valid = 1'b1;
                  next_state.store_addr = k + regs.main_base;
                  next_state.p = k + 18'h00001;
                  next_state.fsm = st_look;
                  do_void = 1'b1;
                end
                cific_pkg::I_COPY_IN, cific_pkg::I_COPY_OUT:
                begin
                  // count above 1777 octal is not trapped in either variant
                  next_state.copy.start = 1'b1;
                  next_state.copy.inward = fi == cific_pkg::I_COPY_IN;
                  next_state.copy.count = regs.index_j + k;
                  next_state.copy.cm_addr = regs.address_reg_zero +
                                            regs.main_base;
                  next_state.copy.ext_addr = regs.operand_reg_zero[23:0] +
                                             regs.external_base;
                  next_state.fsm = st_copy;
                end
                cific_pkg::I_XEXIT:
                begin
                  next_state.fsm = st_xreq;
                  next_state.xchg.req_addr = regs.exit_mode ?
                    k + regs.index_j + regs.main_base :
                    regs.normal_exit_pointer[17:0];
                end
                default:
                  next_state.fsm = next_state.fsm;
              endcase
            cific_pkg::FM_JUMP:
            begin
              tgt = (pw[53:51] == 3'h0) ? k : regs.index_i + k;
              next_state.p = tgt;
              next_state.fsm = st_look;
              next_state.branch_chk = nonseq_variant;
              do_void = !nonseq_variant;
            end
            default:
              if (fm >= cific_pkg::FM_XBR && fm < 6'h08 && taken)
              begin
                next_state.p = k;
                next_state.fsm = st_look;
                next_state.branch_chk = 1'b1;
              end
          endcase
        end
      st_copy:
        if (copy_done)
          next_state.fsm = (state.parcel == 2'h0) ? st_look : st_issue;
      st_xreq:
        next_state.xchg.request = 1'b1;
      st_xchg:
      begin
        next_state.xchg.ref_valid = 1'b1;
        next_state.xchg.ref_addr = state.xchg_base + {14'h0000, state.xcnt};
        next_state.xcnt = state.xcnt + 4'h1;
        if (state.xcnt == cific_pkg::XCHG_LAST)
          next_state.fsm = st_xend;
      end
      st_xend:
      begin
        next_state.p = xchg_new_p;
        next_state.stopped = 1'b0;
        next_state.fsm = st_look;
        do_void = 1'b1;
      end
      default:
        next_state.fsm = st_stop;
    endcase

    // exchange starts only when memory control grants it
    if (xchg_go && (state.fsm == st_look || state.fsm == st_load ||
        state.fsm == st_issue || state.fsm == st_xreq ||
        state.fsm == st_stop))
    begin
      next_state = state;
      next_state.push = 1'b0;
      next_state.mem_req = 1'b0;
      next_state.issue_valid = 1'b0;
      next_state.copy.start = 1'b0;
      next_state.store_valid = 1'b0;
      next_state.void_stk = 1'b0;
      next_state.mul_last = 1'b0;
      if (mem_valid)
        next_state.fetch_busy = 1'b0;
      next_state.drop = mem_valid ? 1'b0 : state.drop;
      next_state.xchg.request = 1'b0;
      next_state.xchg_base = xchg_pkg_addr;
      next_state.xcnt = 4'h0;
      next_state.fsm = st_xchg;
      do_void = 1'b0;
    end
    if (state.fsm != st_xreq)
      next_state.xchg.request = 1'b0;

    // a read still in flight returns stale code and must be thrown away
    if (do_void)
    begin
      next_state.void_stk = 1'b1;
      next_state.push = 1'b0;
      next_state.drop = next_state.fetch_busy;
      next_state.fetch_p = next_state.p;
    end
    pw = at_parcel(next_state.issue_word_register, next_state.parcel);
    next_state.sel_i = pw[53:51];
    next_state.sel_j = pw[50:48];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state <= '0;
    else
      state <= next_state;
  end

  assign mem_req = state.mem_req;
  assign mem_addr = state.mem_addr;
  assign issue_valid = state.issue_valid;
  assign issue_word = state.issue_word;
  assign issue_len = state.issue_len;
  assign issue_unit = state.issue_unit;
  assign sel_i = state.sel_i;
  assign sel_j = state.sel_j;
  assign copy = state.copy;
  assign xchg = state.xchg;
  assign store_valid = state.store_valid;
  assign store_addr = state.store_addr;
  assign stopped = state.stopped;
  assign program_address = state.p;
endmodule // cific_control

// ===== rtl/cific_pkg.sv
// constants, types and carriers of the instruction fetch and issue control
package cific_pkg;
  localparam int DEPTH = 12;
  localparam int WORD_W = 60;
  localparam int ADDR_W = 18;
  localparam logic [17:0] AHEAD = 18'h00002;
  localparam logic [3:0] XCHG_LAST = 4'hf;
  localparam logic [11:0] RANK_OFF_TEN = 12'h3ff;
  localparam logic [11:0] RANK_OFF_FOUR = 12'h00f;
  localparam logic [5:0] MUL_TIME = 6'h05;
  localparam logic [5:0] DIV_TIME = 6'h14;
  localparam logic [5:0] GEN_TIME = 6'h03;
  localparam logic [5:0] DIV_OVERLAP = 6'h02;
  localparam logic [5:0] FM_EXIT = 6'h00;
  localparam logic [5:0] FM_SEQ = 6'h01;
  localparam logic [5:0] FM_JUMP = 6'h02;
  localparam logic [5:0] FM_XBR = 6'h03;
  localparam logic [5:0] FM_MUL_LO = 6'h20;
  localparam logic [5:0] FM_MUL_HI = 6'h22;
  localparam logic [5:0] FM_DIV_LO = 6'h24;
  localparam logic [5:0] FM_DIV_HI = 6'h25;
  localparam logic [2:0] I_RJ = 3'h0;
  localparam logic [2:0] I_COPY_IN = 3'h1;
  localparam logic [2:0] I_COPY_OUT = 3'h2;
  localparam logic [2:0] I_XEXIT = 3'h3;
  localparam logic [1:0] MAINT_TEN = 2'h1;
  localparam logic [1:0] MAINT_FOUR = 2'h2;
  localparam logic [10:0] EXP_INF = 11'h3ff;
  localparam logic [10:0] EXP_IND = 11'h7ff;

  typedef enum logic [1:0] {unit_gen, unit_mul, unit_div} cific_unit_type;

  typedef struct packed {
    logic [17:0] index_i;
    logic [17:0] index_j;
    logic [59:0] operand_j;
    logic [17:0] address_reg_zero;
    logic [59:0] operand_reg_zero;
    logic [17:0] main_base;
    logic [23:0] external_base;
    logic [23:0] normal_exit_pointer;
    logic [23:0] error_exit_pointer;
    logic [17:0] monitor_address;
    logic        exit_mode;
  } cific_regs_type;

  typedef struct packed {
    logic        start;
    logic        inward;
    logic [17:0] count;
    logic [17:0] cm_addr;
    logic [23:0] ext_addr;
  } cific_copy_type;

  typedef struct packed {
    logic        request;
    logic [17:0] req_addr;
    logic        ref_valid;
    logic [17:0] ref_addr;
  } cific_xchg_type;
endpackage

// ===== rtl/cific_stack.sv
// word stack and address stack with registered match output
`timescale 1ns/1ps
module cific_stack
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        void_stacks,
  input  wire logic        push,
  input  wire logic [59:0] push_word,
  input  wire logic [17:0] push_addr,
  input  wire logic [11:0] rank_off,
  input  wire logic [17:0] look_addr,
  output logic             hit,
  output logic [59:0]      hit_word
);
  typedef struct packed {
    logic [11:0][59:0] words;
    logic [11:0][17:0] addrs;
    logic [11:0]       valid;
    logic              hit;
    logic [59:0]       hit_word;
  } cific_stack_type;

  cific_stack_type state;
  cific_stack_type next_state;
  logic [11:0]     match;

  genvar g;
  generate
    for (g = 0; g < cific_pkg::DEPTH; g++)
    begin : g_rank
      assign match[g] = state.valid[g] && !rank_off[g] &&
                        state.addrs[g] == look_addr;
    end
  endgenerate

  always_comb
  begin
    next_state = state;
    next_state.hit = 1'b0;
    next_state.hit_word = state.hit_word;
    // newest rank wins, so duplicated entries stay harmless
    for (int r = 0; r < cific_pkg::DEPTH; r++)
    begin
      if (match[r])
      begin
        next_state.hit = 1'b1;
        next_state.hit_word = state.words[r];
      end
    end
    if (void_stacks)
    begin
      next_state.valid = 12'h000;
      next_state.addrs = '0;
    end
    else if (push)
    begin
      for (int r = 0; r < cific_pkg::DEPTH - 1; r++)
      begin
        next_state.words[r] = state.words[r+1];
        next_state.addrs[r] = state.addrs[r+1];
        next_state.valid[r] = state.valid[r+1];
      end
      next_state.words[11] = push_word;
      next_state.addrs[11] = push_addr;
      next_state.valid[11] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state <= '0;
    else
      state <= next_state;
  end

  assign hit = state.hit;
  assign hit_word = state.hit_word;
endmodule // cific_stack

// ===== tb/cific_control_asserts.sv
// port checker of the instruction fetch and issue control
`timescale 1ns/1ps
module cific_control_asserts
(
  input wire logic                      clk,
  input wire logic                      srst,
  input wire logic                      overlap_units,
  input wire logic                      xchg_go,
  input wire logic [17:0]               xchg_pkg_addr,
  input wire logic                      mem_req,
  input wire logic                      issue_valid,
  input wire logic [59:0]               issue_word,
  input wire cific_pkg::cific_unit_type issue_unit,
  input wire cific_pkg::cific_copy_type copy,
  input wire cific_pkg::cific_xchg_type xchg
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic mul;
  logic div;
  assign mul = issue_valid && issue_unit == cific_pkg::unit_mul;
  assign div = issue_valid && issue_unit == cific_pkg::unit_div;
  // a fetch answer takes at least one cycle, so no two requests in a row
  chk_fetch_single: assert property (mem_req |=> !mem_req)
    else $error("fetch requests back to back");
  chk_mul_gap: assert property (overlap_units && mul |=> !mul)
    else $error("multiply issued in consecutive cycles");
  chk_mul_wait: assert property (!overlap_units && mul |=> !mul [*3])
    else $error("multiply issued before previous completed");
  chk_div_gap: assert property (div |=> !div [*8])
    else $error("divide overlap too large");
  chk_copy_issue: assert property (copy.start |->
    issue_valid && issue_word[59:54] == 6'h01)
    else $error("copy start without copy issue");
  chk_copy_dir: assert property (copy.start |->
    copy.inward == (issue_word[53:51] == cific_pkg::I_COPY_IN))
    else $error("copy direction wrong");
  chk_xchg_hold: assert property (xchg.request && !xchg_go
    |=> xchg.request)
    else $error("exchange request dropped before grant");
  chk_xchg_refs: assert property ($rose(xchg.ref_valid) |->
    xchg.ref_addr == $past(xchg_pkg_addr) ##1 xchg.ref_valid [*7])
    else $error("exchange references wrong");
endmodule // cific_control_asserts

bind cific_control cific_control_asserts u_chk (.clk, .srst, .overlap_units,
  .xchg_go, .xchg_pkg_addr, .mem_req, .issue_valid, .issue_word, .issue_unit,
  .copy, .xchg);

// ===== tb/cific_mem_model.sv
// memory control model: fetch answers, copy done and exchange grant
`timescale 1ns/1ps
module cific_mem_model
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic [17:0] mem_addr,
  input  wire logic        copy_start,
  input  wire logic        xchg_request,
  output logic             mem_valid,
  output logic [59:0]      mem_data,
  output logic             copy_done,
  output logic             xchg_go
);
  logic [59:0] prog [64];
  logic [1:0]  left;
  logic        busy;
  logic [5:0]  addr;
  always_ff @(posedge clk)
  begin
    mem_valid <= 1'b0;
    // data is not held once the answer cycle is over
    mem_data  <= ~mem_data;
    copy_done <= copy_start;
    xchg_go   <= xchg_request && !xchg_go;
    if (srst)
    begin
      busy     <= 1'b0;
      mem_data <= 60'h0;
    end
    else if (mem_req)
    begin
      busy <= 1'b1;
      addr <= mem_addr[5:0];
      left <= lat;
    end
    else if (busy && left == 2'h0)
    begin
      busy      <= 1'b0;
      mem_valid <= 1'b1;
      mem_data  <= prog[addr];
    end
    else if (busy)
      left <= left - 2'h1;
  end
endmodule // cific_mem_model

// ===== tb/tb_cific_control.sv
// self-checking bench of the instruction fetch and issue control
`timescale 1ns/1ps
module tb_cific_control;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic nsq = 1'b0;
  logic ovl = 1'b1;
  logic [1:0] mr = 2'h0;
  logic permit = 1'b1;
  logic [1:0] lat = 2'h0;
  cific_pkg::cific_regs_type regs = '0;
  logic mem_valid, copy_done, xchg_go, mem_req, issue_valid, stopped;
  logic [59:0] mem_data, issue_word;
  logic [17:0] mem_addr;
  logic [2:0] issue_len;
  cific_pkg::cific_unit_type issue_unit;
  cific_pkg::cific_copy_type copy;
  cific_pkg::cific_xchg_type xchg;
  logic [59:0] q [$];
  logic [14:0] p;
  logic [5:0] ops [3] = '{6'h08, 6'h20, 6'h24};
  int fail_count = 0, n_tests = 0, seed = 1, cycles = 0, fetches = 0, f0;
  always #2 clk = ~clk;
  cific_control DUT (.clk, .srst, .nonseq_variant(nsq), .overlap_units(ovl),
    .maint_rank_off(mr), .issue_permit(permit), .mem_valid, .mem_data,
    .exit_to_monitor(1'b0), .regs, .copy_done, .xchg_go,
    .xchg_pkg_addr(18'h00100), .xchg_new_p(18'h00030), .mem_req, .mem_addr,
    .issue_valid, .issue_word, .issue_len, .issue_unit, .sel_i(), .sel_j(),
    .copy, .xchg, .store_valid(), .store_addr(), .stopped,
    .program_address());
  cific_mem_model mem (.clk, .srst, .lat, .mem_req, .mem_addr,
    .copy_start(copy.start), .xchg_request(xchg.request), .mem_valid,
    .mem_data, .copy_done, .xchg_go);
  task automatic check(input string what, input logic [59:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rst_on(input logic s, o, input logic [1:0] m);
    @(negedge clk);
    srst = 1'b1;
    {nsq, ovl, mr} = {s, o, m};
    regs = '0;
    lat = 2'($random(seed));
    q.delete();
    for (int a = 0; a < 64; a++)
      mem.prog[a] = 60'h0;
  endtask
  task automatic put(input int w, input logic [5:0] op);
    p = {op, 9'($random(seed))};
    mem.prog[w / 4][59 - 15 * (w % 4) -: 15] = p;
  endtask
  task automatic run(input string name, input int n);
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (n) @(negedge clk);
    check("pending", 60'(q.size()), 60'h0);
    $display("done %s", name);
  endtask
  // permit is random so issue stalls land at arbitrary parcels
  always @(negedge clk)
    permit <= ($random(seed) & 3) != 0;
  // outputs are looked at half a cycle after the edge that launched them
  always @(negedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict();
    end
    if (!srst && mem_req)
      fetches++;
    if (!srst && q.size() > 0 && copy.start)
      check("copy", {41'h1, copy.inward, copy.count}, q.pop_front());
    else if (!srst && q.size() > 0 && issue_valid && issue_word[59:57] != 0)
      check("issue", {40'h0, issue_unit, issue_len, issue_word[59:45]},
        q.pop_front());
  end
  initial
  begin
    // each unit kind, both variants, pipelined and not; 00 ends the run
    for (int v = 0; v < 6; v++)
    begin
      rst_on(v[0], v < 3, 2'h0);
      for (int w = 0; w < 16; w++)
      begin
        put(w, ops[v % 3]);
        q.push_back({40'h0, 2'(v % 3), 3'h1, p});
      end
      run("units", 450);
      check("stop", 60'(stopped), 60'(!nsq));
    end
    // three word loop closed by 04; ranks 0-9 off forces refetch
    for (int m = 0; m < 2; m++)
    begin
      rst_on(1'b0, 1'b1, m ? cific_pkg::MAINT_TEN : 2'h0);
      for (int w = 0; w < 8; w++)
        put(w, 6'h08);
      mem.prog[2] = {6'h04, 54'h0};
      for (int r = 0; r < 24; r++)
        q.push_back({40'h0, 2'h0, 3'h1,
          mem.prog[r % 8 / 4][59 - 15 * (r % 4) -: 15]});
      run("loop", 240);
      f0 = fetches;
      repeat (40) @(negedge clk);
      check("refetch", 60'(fetches != f0), 60'(m));
    end
    // inward and outward copy, then the two parcels behind it
    for (int d = 1; d < 3; d++)
    begin
      rst_on(1'b0, 1'b1, 2'h0);
      regs.index_j = 18'($random(seed)) & 18'h001ff;
      mem.prog[0] = {6'h01, 3'(d), 3'h1, 18'h00123, 30'h0};
      q.push_back({41'h1, d == 1, regs.index_j + 18'h00123});
      for (int w = 2; w < 4; w++)
      begin
        put(w, 6'h08);
        q.push_back({40'h0, 2'h0, 3'h1, p});
      end
      run("copy", 200);
    end
    print_verdict();
  end
endmodule // tb_cific_control
